// ==== sideband_consts.svh ====
// Purpose : constants for the switch side-band ports
// Assumes : single core clock, 25 MHz
// Notes   : offsets, field positions, reset value and timing counts live here; the checker hard-codes address bits 22:2 and 23
`ifndef SIDEBAND_CONSTS_SVH
`define SIDEBAND_CONSTS_SVH

`define CFG_ADDR_W        24
`define CFG_ACC_BIT       23
`define CFG_DATA_W        32
`define CFG_WORD_LSB      2
`define CFG_WORD_W        21
`define CFG_NUM_WORDS     16
`define CFG_TIMEOUT_CYC   64
`define CFG_TMO_W         7
`define CFG_RESET_WORD    32'h00000000
`define DBG_SEL_W         11
`define DBG_DATA_W        32
`define DBG_WIDE_FIRST    11'h001
`define DBG_WIDE_LAST     11'h00A
`define DBG_NARROW_FIRST  11'h00B
`define DBG_NARROW_LAST   11'h061
`define WIDE_DATA_W       27
`define WIDE_CNT_W        3
`define NARROW_DATA_W     8
`define NARROW_CNT_W      1
`define NUM_WIDE          5
`define NUM_NARROW        48
`define NUM_PORTS         53

`endif

// ==== sideband_pkg.sv ====
// Purpose : types for the switch side-band ports
// Assumes : constants come from sideband_consts.svh
// Notes   : configuration port handshake states
package sideband_pkg;
   typedef enum logic [1:0] {
      CFG_IDLE = 2'b00,
      CFG_BUSY = 2'b01,
      CFG_DONE = 2'b11
   } cfg_state_e;
endpackage : sideband_pkg

// ==== pause_hysteresis.sv ====
// Purpose : per-port pause status with hysteresis thresholds
// Assumes : fill level supplied by the resource manager, core clock
// Notes   : xoff set at or above the high mark, cleared at or below the low mark
`timescale 1ns/1ns
module pause_hysteresis #(
   parameter int LVL_W = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [LVL_W-1:0] fill_level,
   input  wire logic [LVL_W-1:0] xoff_mark,
   input  wire logic [LVL_W-1:0] xon_mark,
   output logic                  xoff
);
   logic xoff_q;
   logic xoff_d;

   always_comb begin
      xoff_d = xoff_q;
      if (!xoff_q && (fill_level >= xoff_mark)) begin
         xoff_d = 1'b1;
      end else if (xoff_q && (fill_level <= xon_mark)) begin
         xoff_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         xoff_q <= 1'b0;
      end else begin
         xoff_q <= xoff_d;
      end
   end

   assign xoff = xoff_q;
endmodule : pause_hysteresis

// ==== switch_sideband_ports.sv ====
// Purpose : configuration slave, pause lines and debug mux of the switch core
// Assumes : one core clock sys_clk at 25 MHz, async active-low rst_n
// Notes   : register contents are a small word store standing in for the core
//
// Notes on behaviour
// - write direction high, read direction low
// - byte address, whole words, low bits dropped
// - ready stretches variable-latency transfers
// - internal timeout aborts with slave error
// - unmapped word address gives slave error
// - outgoing pause uses hysteresis, no short pulses
// - external xoff blocks new packet starts
// - one pause input per interface
// - eleven-bit select picks 32-bit debug word
// - select and debug data both pipelined
// - selects 1-10 show wide rx/tx words
// - selects 11-97 show narrow rx/tx words
// - address bit 23 is accumulator control
`timescale 1ns/1ns
`include "sideband_consts.svh"
module switch_sideband_ports #(
   parameter int NUM_PORTS   = `NUM_PORTS,
   parameter int NUM_WIDE    = `NUM_WIDE,
   parameter int NUM_WORDS   = `CFG_NUM_WORDS,
   parameter int TIMEOUT_CYC = `CFG_TIMEOUT_CYC,
   parameter int LVL_W       = 16
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst_n,
   // configuration port
   input  wire logic [`CFG_ADDR_W-1:0]        apb_paddr,
   input  wire logic                          apb_psel,
   input  wire logic                          apb_penable,
   input  wire logic                          apb_pwrite,
   input  wire logic [`CFG_DATA_W-1:0]        apb_pwdata,
   output logic                               apb_pready,
   output logic [`CFG_DATA_W-1:0]             apb_prdata,
   output logic                               apb_pslverr,
   // internal access latency from the core, cycles before a word is served
   input  wire logic [`CFG_TMO_W-1:0]         core_latency,
   output logic                               acc_flag,
   // pause lines
   input  wire logic [NUM_PORTS-1:0]          ext_pause_in,
   output logic [NUM_PORTS-1:0]               pfc_status_out,
   input  wire logic [NUM_PORTS*LVL_W-1:0]    fill_level,
   input  wire logic [LVL_W-1:0]              xoff_mark,
   input  wire logic [LVL_W-1:0]              xon_mark,
   // egress scheduler view
   input  wire logic [NUM_PORTS-1:0]          pkt_pending,
   input  wire logic [NUM_PORTS-1:0]          pkt_end,
   output logic [NUM_PORTS-1:0]               pkt_start,
   output logic [NUM_PORTS-1:0]               pkt_busy,
   // packet buses observed by the debug mux
   input  wire logic [NUM_WIDE*32-1:0]        wide_rx_bus,
   input  wire logic [NUM_WIDE*32-1:0]        wide_tx_bus,
   input  wire logic [(NUM_PORTS-NUM_WIDE)*11-1:0] narrow_rx_bus,
   input  wire logic [(NUM_PORTS-NUM_WIDE)*11-1:0] narrow_tx_bus,
   // debug read port
   input  wire logic [`DBG_SEL_W-1:0]         debug_read_select,
   output logic [`DBG_DATA_W-1:0]             debug_read_data
);
   import sideband_pkg::*;

   localparam int NARROW   = NUM_PORTS - NUM_WIDE;
   localparam int IDX_W    = $clog2(NUM_WORDS);
   // one observed bus word: data, byte count, last and first
   localparam int WIDE_W   = `WIDE_DATA_W + `WIDE_CNT_W + 2;
   localparam int NARROW_W = `NARROW_DATA_W + `NARROW_CNT_W + 2;
   localparam int WIDX_W   = $clog2(NUM_WIDE);
   localparam int NIDX_W   = $clog2(NARROW);

   // ----------------------------------------------------------------
   // configuration port
   // ----------------------------------------------------------------
   logic [`CFG_DATA_W-1:0]   mem_q [NUM_WORDS];
   logic [`CFG_DATA_W-1:0]   mem_d [NUM_WORDS];
   cfg_state_e               state_q;
   cfg_state_e               state_d;
   logic [`CFG_TMO_W-1:0]    wait_q;
   logic [`CFG_TMO_W-1:0]    wait_d;
   logic [`CFG_DATA_W-1:0]   rdata_q;
   logic [`CFG_DATA_W-1:0]   rdata_d;
   logic                     err_q;
   logic                     err_d;
   logic                     acc_q;
   logic                     acc_d;
   logic [`CFG_WORD_W-1:0]   word_addr;
   logic                     mapped;
   logic                     timed_out;
   logic                     store_we;
   logic [IDX_W-1:0]         store_idx;

   // byte lanes are ignored, bit 23 is not part of the word address
   assign word_addr = apb_paddr[`CFG_ACC_BIT-1:`CFG_WORD_LSB];
   assign mapped    = (word_addr < `CFG_WORD_W'(NUM_WORDS));
   assign timed_out = (wait_q >= `CFG_TMO_W'(TIMEOUT_CYC - 1));
   assign store_idx = word_addr[IDX_W-1:0];

   always_comb begin
      state_d = state_q;
      wait_d  = wait_q;
      rdata_d = rdata_q;
      err_d   = 1'b0;
      acc_d   = acc_q;
      store_we = 1'b0;
      unique case (state_q)
         CFG_IDLE: begin
            if (apb_psel && !apb_penable) begin
               state_d = CFG_BUSY;
               wait_d  = '0;
               acc_d   = apb_paddr[`CFG_ACC_BIT];
            end
         end
         CFG_BUSY: begin
            wait_d = wait_q + 1'b1;
            if (!apb_psel) begin
               state_d = CFG_IDLE;
            end else if (!mapped) begin
               state_d = CFG_DONE;
               err_d   = 1'b1;
               rdata_d = '0;
            end else if (timed_out) begin
               state_d = CFG_DONE;
               err_d   = 1'b1;
               rdata_d = '0;
            end else if (wait_q >= core_latency) begin
               state_d = CFG_DONE;
               store_we = apb_pwrite;
               if (!apb_pwrite) begin
                  rdata_d = mem_q[store_idx];
               end
            end
         end
         CFG_DONE: begin
            state_d = CFG_IDLE;
         end
         default: state_d = CFG_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= CFG_IDLE;
         wait_q  <= '0;
         rdata_q <= '0;
         err_q   <= 1'b0;
         acc_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         err_q   <= err_d;
         acc_q   <= acc_d;
      end
   end

   // ready only in the done state, error only alongside it
   assign apb_pready  = (state_q == CFG_DONE);
   assign apb_pslverr = apb_pready & err_q;
   assign apb_prdata  = rdata_q;
   assign acc_flag    = acc_q;

   // ----------------------------------------------------------------
   // word store behind the configuration port
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_WORDS; i++) begin
         mem_d[i] = mem_q[i];
      end
      // refused accesses never raise the write strobe
      if (store_we) begin
         mem_d[store_idx] = apb_pwdata;
      end
   end

   // writes land on the edge that ends the wait
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            mem_q[i] <= `CFG_RESET_WORD;
         end
      end else begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            mem_q[i] <= mem_d[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // pause lines and egress start gating
   // ----------------------------------------------------------------
   logic [NUM_PORTS-1:0] busy_q;
   logic [NUM_PORTS-1:0] busy_d;
   logic [NUM_PORTS-1:0] start_c;

   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++) begin : g_port
         pause_hysteresis #(
            .LVL_W (LVL_W)
         ) u_hyst (
            .sys_clk    (sys_clk),
            .rst_n      (rst_n),
            .fill_level (fill_level[g*LVL_W +: LVL_W]),
            .xoff_mark  (xoff_mark),
            .xon_mark   (xon_mark),
            .xoff       (pfc_status_out[g])
         );
         // own pause input gates only its own port
         assign start_c[g] = pkt_pending[g] & ~busy_q[g] & ~ext_pause_in[g];
         always_comb begin
            busy_d[g] = busy_q[g];
            if (start_c[g]) begin
               busy_d[g] = 1'b1;
            end else if (pkt_end[g]) begin
               busy_d[g] = 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= '0;
      end else begin
         busy_q <= busy_d;
      end
   end

   assign pkt_start = start_c;
   assign pkt_busy  = busy_q;

   // ----------------------------------------------------------------
   // debug read mux
   // ----------------------------------------------------------------
   logic [`DBG_SEL_W-1:0]  sel_q;
   logic [`DBG_SEL_W-1:0]  sel_d;
   logic [`DBG_DATA_W-1:0] dbg_q;
   logic [`DBG_DATA_W-1:0] dbg_d;
   logic [`DBG_SEL_W-1:0]  off;
   logic [`DBG_SEL_W-2:0]  idx;
   logic                   sel_wide;
   logic                   sel_narrow;
   logic [`DBG_DATA_W-1:0] wide_rx_word   [NUM_WIDE];
   logic [`DBG_DATA_W-1:0] wide_tx_word   [NUM_WIDE];
   logic [`DBG_DATA_W-1:0] narrow_rx_word [NARROW];
   logic [`DBG_DATA_W-1:0] narrow_tx_word [NARROW];

   // one word per port and direction, narrow words zero-extended
   genvar p;
   generate
      for (p = 0; p < NUM_WIDE; p++) begin : g_wide
         assign wide_rx_word[p] = wide_rx_bus[p*WIDE_W +: WIDE_W];
         assign wide_tx_word[p] = wide_tx_bus[p*WIDE_W +: WIDE_W];
      end
      for (p = 0; p < NARROW; p++) begin : g_narrow
         assign narrow_rx_word[p] = `DBG_DATA_W'(narrow_rx_bus[p*NARROW_W +: NARROW_W]);
         assign narrow_tx_word[p] = `DBG_DATA_W'(narrow_tx_bus[p*NARROW_W +: NARROW_W]);
      end
   endgenerate

   assign sel_wide   = (sel_q >= `DBG_WIDE_FIRST) && (sel_q <= `DBG_WIDE_LAST);
   assign sel_narrow = (sel_q >= `DBG_NARROW_FIRST) && (sel_q <= `DBG_NARROW_LAST);

   always_comb begin
      sel_d = debug_read_select;
      dbg_d = '0;
      off   = '0;
      idx   = '0;
      if (sel_wide) begin
         off = sel_q - `DBG_WIDE_FIRST;
         idx = off[`DBG_SEL_W-1:1];
         // odd selects rx, even selects tx
         if (!off[0]) begin
            dbg_d = wide_rx_word[idx[WIDX_W-1:0]];
         end else begin
            dbg_d = wide_tx_word[idx[WIDX_W-1:0]];
         end
      end else if (sel_narrow) begin
         off = sel_q - `DBG_NARROW_FIRST;
         idx = off[`DBG_SEL_W-1:1];
         if (!off[0]) begin
            dbg_d = narrow_rx_word[idx[NIDX_W-1:0]];
         end else begin
            dbg_d = narrow_tx_word[idx[NIDX_W-1:0]];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= '0;
         dbg_q <= '0;
      end else begin
         sel_q <= sel_d;
         dbg_q <= dbg_d;
      end
   end

   assign debug_read_data = dbg_q;
endmodule : switch_sideband_ports

// ==== sideband_checker.sv ====
// Purpose : concurrent checks on the side-band ports
// Assumes : one core clock, async active-low reset
// Notes   : bound to switch_sideband_ports after the module
`timescale 1ns/1ns
`include "sideband_consts.svh"
module sideband_checker #(
   parameter int NUM_PORTS   = `NUM_PORTS,
   parameter int TIMEOUT_CYC = `CFG_TIMEOUT_CYC
) (
   input wire logic                   sys_clk,
   input wire logic                   rst_n,
   input wire logic [`CFG_ADDR_W-1:0] apb_paddr,
   input wire logic                   apb_psel,
   input wire logic                   apb_penable,
   input wire logic                   apb_pready,
   input wire logic                   apb_pslverr,
   input wire logic                   acc_flag,
   input wire logic [NUM_PORTS-1:0]   ext_pause_in,
   input wire logic [NUM_PORTS-1:0]   pkt_start,
   input wire logic [NUM_PORTS-1:0]   pkt_busy,
   input wire logic [NUM_PORTS-1:0]   pkt_end,
   input wire logic [`DBG_SEL_W-1:0]  debug_read_select,
   input wire logic [`DBG_DATA_W-1:0] debug_read_data
);
   localparam int TMAX = TIMEOUT_CYC + 4;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_setup;
      apb_psel && !apb_penable;
   endsequence
   sequence s_unmapped;
      s_setup ##0 (apb_paddr[22:2] >= `CFG_NUM_WORDS);
   endsequence
   chk_err_ready: assert property (apb_pslverr |-> apb_pready)
      else $error("slave error outside final cycle");
   chk_ready_pulse: assert property (apb_pready |=> !apb_pready)
      else $error("ready held longer than one cycle");
   chk_ready_bound: assert property (s_setup |-> ##[2:TMAX] apb_pready)
      else $error("transfer not ended within timeout");
   chk_unmapped_err: assert property (s_unmapped |-> ##2 (apb_pready && apb_pslverr))
      else $error("unmapped access without slave error");
   chk_acc_capture: assert property (s_setup |=> acc_flag == $past(apb_paddr[23]))
      else $error("accumulator bit not captured");
   chk_pause_blocks: assert property ((pkt_start & (ext_pause_in | pkt_busy)) == '0)
      else $error("packet started while paused or busy");
   chk_busy_follows: assert property (|pkt_start |=>
      (pkt_busy & $past(pkt_start)) == $past(pkt_start))
      else $error("started port not busy");
   chk_busy_holds: assert property (|(pkt_busy & ~pkt_end) |=>
      ($past(pkt_busy) & ~$past(pkt_end) & ~pkt_busy) == '0)
      else $error("ongoing packet dropped");
   chk_dbg_zero: assert property ((debug_read_select == 11'h000 ||
      debug_read_select > `DBG_NARROW_LAST) |-> ##2 debug_read_data == 32'h00000000)
      else $error("unused debug select not zero");
endmodule : sideband_checker
bind switch_sideband_ports sideband_checker #(.NUM_PORTS(NUM_PORTS), .TIMEOUT_CYC(TIMEOUT_CYC))
   i_sideband_checker (.sys_clk, .rst_n, .apb_paddr, .apb_psel, .apb_penable, .apb_pready,
   .apb_pslverr, .acc_flag, .ext_pause_in, .pkt_start, .pkt_busy, .pkt_end,
   .debug_read_select, .debug_read_data);

// ==== apb_master_model.sv ====
// Purpose : configuration bus master standing in for the cpu side
// Assumes : drives and samples on falling edges, ends on the next rising edge
// Notes   : released address and data are inverted so stale values never match
`timescale 1ns/1ns
`include "sideband_consts.svh"
module apb_master_model (
   input  wire logic                   sys_clk,
   input  wire logic                   apb_pready,
   input  wire logic [`CFG_DATA_W-1:0] apb_prdata,
   input  wire logic                   apb_pslverr,
   output logic [`CFG_ADDR_W-1:0]      apb_paddr,
   output logic                        apb_psel,
   output logic                        apb_penable,
   output logic                        apb_pwrite,
   output logic [`CFG_DATA_W-1:0]      apb_pwdata
);
   initial begin
      apb_paddr = 24'h5A5A5A;
      apb_psel = 1'b0;
      apb_penable = 1'b0;
      apb_pwrite = 1'b0;
      apb_pwdata = 32'hA5A5A5A5;
   end
   // word index scaled to a byte address, low bits carry junk lanes
   task automatic xfer(input logic acc, input logic [20:0] word, input logic [1:0] lo,
      input logic wr, input logic [31:0] wd, output logic [31:0] rd, output logic er);
      @(negedge sys_clk);
      apb_paddr = {acc, word, lo};
      apb_pwrite = wr;
      apb_pwdata = wd;
      apb_psel = 1'b1;
      apb_penable = 1'b0;
      @(negedge sys_clk);
      apb_penable = 1'b1;
      // ready and its data are settled mid-cycle; the transfer ends on the next rise
      while (apb_pready !== 1'b1) begin
         @(negedge sys_clk);
      end
      rd = apb_prdata;
      er = apb_pslverr;
      @(posedge sys_clk);
      @(negedge sys_clk);
      apb_psel = 1'b0;
      apb_penable = 1'b0;
      apb_paddr = ~apb_paddr;
      apb_pwdata = ~apb_pwdata;
   endtask : xfer
endmodule : apb_master_model

// ==== tb.sv ====
// Purpose : self-checking bench for switch_sideband_ports
// Assumes : 25 MHz core clock, timeout shortened to 8 cycles
// Notes   : bus cycles come from apb_master_model
`timescale 1ns/1ns
`include "sideband_consts.svh"
module tb;
   localparam int NP = `NUM_PORTS;
   logic                 sys_clk, rst_n, apb_psel, apb_penable, apb_pwrite;
   logic                 apb_pready, apb_pslverr, acc_flag, er;
   logic [23:0]          apb_paddr;
   logic [31:0]          apb_pwdata, apb_prdata, debug_read_data, rd;
   logic [6:0]           core_latency;
   logic [NP-1:0]        ext_pause_in, pfc_status_out, pkt_pending, pkt_end, pkt_start, pkt_busy;
   logic [NP*16-1:0]     fill_level;
   logic [15:0]          xoff_mark, xon_mark;
   logic [159:0]         wide_rx_bus, wide_tx_bus;
   logic [(NP-5)*11-1:0] narrow_rx_bus, narrow_tx_bus;
   logic [10:0]          debug_read_select;
   int                   bad_count, checks, cyc;
   switch_sideband_ports #(.TIMEOUT_CYC(8)) i_switch_sideband_ports (
      .sys_clk, .rst_n, .apb_paddr, .apb_psel, .apb_penable, .apb_pwrite, .apb_pwdata,
      .apb_pready, .apb_prdata, .apb_pslverr, .core_latency, .acc_flag, .ext_pause_in,
      .pfc_status_out, .fill_level, .xoff_mark, .xon_mark, .pkt_pending, .pkt_end,
      .pkt_start, .pkt_busy, .wide_rx_bus, .wide_tx_bus, .narrow_rx_bus, .narrow_tx_bus,
      .debug_read_select, .debug_read_data);
   apb_master_model i_apb_master_model (.sys_clk, .apb_pready, .apb_prdata, .apb_pslverr,
      .apb_paddr, .apb_psel, .apb_penable, .apb_pwrite, .apb_pwdata);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task results;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end
   task t_cfg;
      core_latency = 7'h00;
      i_apb_master_model.xfer(1'b1, 21'h3, 2'b11, 1'b1, 32'hCAFE0003, rd, er);
      check(er, 0);
      check(acc_flag, 1);
      core_latency = 7'h05;
      i_apb_master_model.xfer(1'b0, 21'h3, 2'b00, 1'b0, 32'h0, rd, er);
      check(rd, 32'hCAFE0003);
      check(acc_flag, 0);
      i_apb_master_model.xfer(1'b0, 21'hF, 2'b01, 1'b1, 32'h0000000F, rd, er);
      check(er, 0);
      i_apb_master_model.xfer(1'b0, 21'h10, 2'b00, 1'b0, 32'h0, rd, er);
      check({rd[30:0], er}, 1);
      $display("t_cfg done");
   endtask : t_cfg
   task t_tmo;
      core_latency = 7'h14;
      i_apb_master_model.xfer(1'b0, 21'h3, 2'b00, 1'b1, 32'h12345678, rd, er);
      check({rd[30:0], er}, 1);
      core_latency = 7'h00;
      i_apb_master_model.xfer(1'b0, 21'h3, 2'b00, 1'b0, 32'h0, rd, er);
      check(rd, 32'hCAFE0003);
      $display("t_tmo done");
   endtask : t_tmo
   task automatic fill_step(input logic [15:0] lvl, input logic exp);
      fill_level[15:0] = lvl;
      repeat (2) @(negedge sys_clk);
      check(pfc_status_out[1:0], {1'b0, exp});
   endtask : fill_step
   task t_pause;
      fill_step(16'h0064, 1'b1);
      fill_step(16'h003C, 1'b1);
      fill_step(16'h001E, 1'b0);
      $display("t_pause done");
   endtask : t_pause
   task t_egress;
      ext_pause_in[2] = 1'b1;
      pkt_pending[2:1] = 2'b11;
      #1 check(pkt_start[2:1], 2'b01);
      @(negedge sys_clk);
      check({pkt_busy[1], pkt_start[1]}, 2'b10);
      ext_pause_in[1] = 1'b1;
      pkt_pending[1] = 1'b0;
      @(negedge sys_clk);
      check(pkt_busy[1], 1);
      pkt_end[1] = 1'b1;
      @(negedge sys_clk);
      pkt_end[1] = 1'b0;
      check(pkt_busy[1], 0);
      ext_pause_in[2] = 1'b0;
      #1 check(pkt_start[2], 1);
      $display("t_egress done");
   endtask : t_egress
   function automatic logic [31:0] dbg_exp(input int s);
      if (s >= 1 && s <= 10)
         return ((s % 2) ? 32'h10000000 : 32'h20000000) + (s - 1) / 2;
      if (s >= 11 && s <= 97)
         return ((s % 2) ? 32'h00000400 : 32'h00000200) | (s - 11) / 2;
      return 32'h00000000;
   endfunction : dbg_exp
   task automatic t_debug;
      int sels[9] = '{0, 1, 2, 9, 10, 11, 12, 97, 98};
      foreach (sels[k]) begin
         debug_read_select = sels[k][10:0];
         @(negedge sys_clk);
         check(debug_read_data, dbg_exp((k == 0) ? 0 : sels[k-1]));
         @(negedge sys_clk);
         check(debug_read_data, dbg_exp(sels[k]));
      end
      $display("t_debug done");
   endtask : t_debug
   initial begin
      rst_n = 1'b0;
      core_latency = 7'h00;
      ext_pause_in = '0;
      pkt_pending = '0;
      pkt_end = '0;
      fill_level = '0;
      xoff_mark = 16'h0050;
      xon_mark = 16'h0028;
      debug_read_select = 11'h000;
      for (int i = 0; i < 5; i++) begin
         wide_rx_bus[i*32+:32] = 32'h10000000 + i;
         wide_tx_bus[i*32+:32] = 32'h20000000 + i;
      end
      for (int i = 0; i < NP - 5; i++) begin
         narrow_rx_bus[i*11+:11] = 11'h400 | i[10:0];
         narrow_tx_bus[i*11+:11] = 11'h200 | i[10:0];
      end
      repeat (3) @(negedge sys_clk);
      rst_n = 1'b1;
      t_cfg();
      t_tmo();
      t_pause();
      t_egress();
      t_debug();
      results();
   end
endmodule : tb
